/* core/psc_top.sv */
// supply comparator control: ahb-lite registers, filter, event outputs
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module psc_top #(
    parameter int unsigned LEVEL_W = psc_pkg::LEVEL_W,
    parameter int unsigned FILT_CYC = psc_pkg::GLITCH_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [psc_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [psc_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [psc_pkg::DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog comparator and dac control
    input wire logic cmp_raw,
    output logic cmp_power_on,
    output logic dac_power_on,
    output logic [LEVEL_W-1:0] dac_code,
    output logic [1:0] dac_range,
    output logic dac_to_inverting,
    output logic [psc_pkg::SEL_W-1:0] pos_input_sel,
    output logic [psc_pkg::SRC_PINS-1:0] pad_input_off,
    // power modes and comparator group
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic group_idle_stop,
    output logic idle_stop_out,
    output logic wake_req,
    // downstream event outputs
    output logic adc_trigger,
    output logic pwm_current_limit,
    output logic pwm_period_trunc,
    output logic pwm_fault,
    output logic int_pulse,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic en;
        logic idle_stop;
        logic [psc_pkg::SEL_W-1:0] sel;
        logic ext;
        logic inv;
        logic range;
        logic [LEVEL_W-1:0] level;
        logic [psc_pkg::STAT_W-1:0] stat;
        logic [psc_pkg::STAT_W-1:0] mask;
        logic [psc_pkg::USE_W-1:0] use_en;
        logic wr_pend;
        logic [psc_pkg::ADDR_W-1:0] wr_addr;
        logic [psc_pkg::DATA_W-1:0] rdata;
        logic adc_trig;
        logic limit;
        logic period;
        logic fault;
        logic ipulse;
        logic irq;
        psc_pkg::psc_range_t rng;
        logic [psc_pkg::SRC_PINS-1:0] pad_off;
    } psc_state_t;

    psc_state_t s_q;
    psc_state_t s_d;

    logic cmp_active;
    logic cmp_sense;
    logic filt_level;
    logic filt_rise;
    logic filt_fall;
    logic addr_phase;
    logic low_power;

    ////////////////////////////////////////////////////////////////////////
    // register decode and read mux

    function automatic logic [psc_pkg::DATA_W-1:0] read_word(
        input logic [psc_pkg::ADDR_W-1:0] a,
        input psc_state_t s,
        input logic state_bit
    );
        logic [psc_pkg::DATA_W-1:0] w;
        w = '0;
        unique case (a)
            psc_pkg::OFF_CTRL: begin
                w[psc_pkg::CTRL_EN_BIT] = s.en;
                w[psc_pkg::CTRL_IDLE_STOP_BIT] = s.idle_stop;
                w[psc_pkg::CTRL_SEL_LSB +: psc_pkg::SEL_W] = s.sel;
                w[psc_pkg::CTRL_EXT_BIT] = s.ext;
                w[psc_pkg::CTRL_STATE_BIT] = state_bit;
                w[psc_pkg::CTRL_INV_BIT] = s.inv;
                w[psc_pkg::CTRL_RANGE_BIT] = s.range;
            end
            psc_pkg::OFF_LEVEL: begin
                w[LEVEL_W-1:0] = s.level;
            end
            psc_pkg::OFF_STAT: begin
                w[psc_pkg::STAT_W-1:0] = s.stat;
            end
            psc_pkg::OFF_MASK: begin
                w[psc_pkg::STAT_W-1:0] = s.mask;
            end
            psc_pkg::OFF_USE: begin
                w[psc_pkg::USE_W-1:0] = s.use_en;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction : read_word

    function automatic psc_pkg::psc_range_t range_of(
        input logic ext,
        input logic range
    );
        psc_pkg::psc_range_t r;
        if (ext) begin
            r = psc_pkg::RANGE_EXTERNAL;
        end else if (range) begin
            r = psc_pkg::RANGE_HALF_SUPPLY;
        end else begin
            r = psc_pkg::RANGE_INTERNAL;
        end
        return r;
    endfunction : range_of

    function automatic logic [psc_pkg::SRC_PINS-1:0] pad_mask(
        input logic en,
        input logic [psc_pkg::SEL_W-1:0] sel
    );
        logic [psc_pkg::SRC_PINS-1:0] m;
        m = '0;
        for (int i = 0; i < psc_pkg::SRC_PINS; i++) begin
            // selected pad loses its digital buffer while enabled
            m[i] = en & (sel == psc_pkg::SEL_W'(i));
        end
        return m;
    endfunction : pad_mask

    function automatic psc_state_t ctrl_load(
        input psc_state_t s,
        input logic [psc_pkg::DATA_W-1:0] wd
    );
        psc_state_t r;
        r = s;
        r.en = wd[psc_pkg::CTRL_EN_BIT];
        r.idle_stop = wd[psc_pkg::CTRL_IDLE_STOP_BIT];
        r.sel = wd[psc_pkg::CTRL_SEL_LSB +: psc_pkg::SEL_W];
        r.ext = wd[psc_pkg::CTRL_EXT_BIT];
        r.inv = wd[psc_pkg::CTRL_INV_BIT];
        r.range = wd[psc_pkg::CTRL_RANGE_BIT];
        return r;
    endfunction : ctrl_load

    ////////////////////////////////////////////////////////////////////////
    // comparator gating and polarity

    assign addr_phase = hsel & htrans[1] & hready;

    // any stop bit in the group halts this comparator in idle
    assign cmp_active = s_q.en
        & ~(idle_mode & (s_q.idle_stop | group_idle_stop));

    // polarity applied ahead of filter and bypass path
    assign cmp_sense = cmp_active & (cmp_raw ^ s_q.inv);

    psc_glitch_filter #(
        .CYC(FILT_CYC)
    ) u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .sample_in(cmp_sense),
        .filt_out(filt_level),
        .rise_pulse(filt_rise),
        .fall_pulse(filt_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [psc_pkg::DATA_W-1:0] wd;
        logic [psc_pkg::STAT_W-1:0] set_v;
        logic [psc_pkg::STAT_W-1:0] clr_v;
        wd = hwdata;
        set_v = '0;
        clr_v = '0;
        s_d = s_q;

        // bus address phase: capture write, fetch read word
        s_d.wr_pend = addr_phase & hwrite;
        if (addr_phase) begin
            s_d.wr_addr = haddr;
        end
        if (addr_phase & ~hwrite) begin
            s_d.rdata = read_word(haddr, s_q, filt_level);
        end

        // bus data phase write
        if (s_q.wr_pend) begin
            unique case (s_q.wr_addr)
                psc_pkg::OFF_CTRL: begin
                    s_d = ctrl_load(s_d, wd);
                end
                psc_pkg::OFF_LEVEL: begin
                    s_d.level = wd[LEVEL_W-1:0];
                end
                psc_pkg::OFF_STAT: begin
                    clr_v = wd[psc_pkg::STAT_W-1:0];
                end
                psc_pkg::OFF_MASK: begin
                    s_d.mask = wd[psc_pkg::STAT_W-1:0];
                end
                psc_pkg::OFF_USE: begin
                    s_d.use_en = wd[psc_pkg::USE_W-1:0];
                end
                default: begin
                    s_d.use_en = s_q.use_en;
                end
            endcase
        end

        // sticky events, set wins over write-one-to-clear
        set_v[psc_pkg::STAT_RISE_BIT] = filt_rise;
        set_v[psc_pkg::STAT_FALL_BIT] = filt_fall;
        s_d.stat = (s_q.stat & ~clr_v) | set_v;

        // adc, period and fault uses act on the rising event independently; current limit follows the filtered level
        s_d.adc_trig = filt_rise & s_q.use_en[psc_pkg::USE_ADC_BIT];
        s_d.limit = filt_level & s_q.use_en[psc_pkg::USE_LIMIT_BIT];
        s_d.period = filt_rise & s_q.use_en[psc_pkg::USE_PERIOD_BIT];
        s_d.fault = filt_rise & s_q.use_en[psc_pkg::USE_FAULT_BIT];
        s_d.ipulse = filt_rise & s_q.mask[psc_pkg::STAT_RISE_BIT];

        // data outputs leave from flops, built from the next state
        s_d.irq = |(s_d.stat & s_d.mask);
        s_d.rng = range_of(s_d.ext, s_d.range);
        s_d.pad_off = pad_mask(s_d.en, s_d.sel);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.en <= 1'b0;
            s_q.idle_stop <= 1'b0;
            s_q.sel <= psc_pkg::SEL_RST;
            s_q.ext <= 1'b0;
            s_q.inv <= 1'b0;
            s_q.range <= 1'b0;
            s_q.level <= psc_pkg::LEVEL_RST;
            s_q.stat <= psc_pkg::STAT_RST;
            s_q.mask <= psc_pkg::MASK_RST;
            s_q.use_en <= psc_pkg::USE_RST;
            s_q.wr_pend <= 1'b0;
            s_q.wr_addr <= '0;
            s_q.rdata <= psc_pkg::RDATA_RST;
            s_q.adc_trig <= 1'b0;
            s_q.limit <= 1'b0;
            s_q.period <= 1'b0;
            s_q.fault <= 1'b0;
            s_q.ipulse <= 1'b0;
            s_q.irq <= 1'b0;
            s_q.rng <= psc_pkg::RANGE_INTERNAL;
            s_q.pad_off <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source select and pad buffers

    assign pad_input_off = s_q.pad_off;

    assign pos_input_sel = s_q.sel;
    assign dac_to_inverting = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // dac and comparator power

    assign dac_power_on = s_q.en;
    assign cmp_power_on = cmp_active;
    assign dac_code = s_q.level;
    assign dac_range = s_q.rng;
    assign idle_stop_out = s_q.idle_stop;

    // unclocked bypass so a stopped clock can still be woken
    assign low_power = sleep_mode | idle_mode;
    assign wake_req = low_power & cmp_sense;

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign adc_trigger = s_q.adc_trig;
    assign pwm_current_limit = s_q.limit;
    assign pwm_period_trunc = s_q.period;
    assign pwm_fault = s_q.fault;
    assign int_pulse = s_q.ipulse;
    assign irq = s_q.irq;

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule : psc_top

/* core/psc_pkg.sv */
// constants and types shared by the supply comparator control block
package psc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_LEVEL = 5'h04;
    localparam logic [4:0] OFF_STAT = 5'h08;
    localparam logic [4:0] OFF_MASK = 5'h0c;
    localparam logic [4:0] OFF_USE = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // comparator_control_reg field positions
    localparam int unsigned CTRL_EN_BIT = 15;
    localparam int unsigned CTRL_IDLE_STOP_BIT = 13;
    localparam int unsigned CTRL_SEL_LSB = 6;
    localparam int unsigned CTRL_EXT_BIT = 5;
    localparam int unsigned CTRL_STATE_BIT = 3;
    localparam int unsigned CTRL_INV_BIT = 1;
    localparam int unsigned CTRL_RANGE_BIT = 0;
    localparam int unsigned SEL_W = 2;
    localparam int unsigned SRC_PINS = 4;

    // reference_level_reg
    localparam int unsigned LEVEL_W = 10;

    // status and mask bits
    localparam int unsigned STAT_W = 2;
    localparam int unsigned STAT_RISE_BIT = 0;
    localparam int unsigned STAT_FALL_BIT = 1;

    // output use enables
    localparam int unsigned USE_W = 4;
    localparam int unsigned USE_ADC_BIT = 0;
    localparam int unsigned USE_LIMIT_BIT = 1;
    localparam int unsigned USE_PERIOD_BIT = 2;
    localparam int unsigned USE_FAULT_BIT = 3;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 10'h000;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
    localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
    localparam logic [USE_W-1:0] USE_RST = 4'h0;
    localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned GLITCH_NS = 66;
    localparam int unsigned GLITCH_CYC =
        (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // reference dac full-scale source
    typedef enum logic [1:0] {
        RANGE_HALF_SUPPLY,
        RANGE_INTERNAL,
        RANGE_EXTERNAL
    } psc_range_t;

endpackage : psc_pkg

/* core/psc_glitch_filter.sv */
// glitch filter and one-cycle edge pulse generator
`timescale 1ns/100ps
module psc_glitch_filter #(
    parameter int unsigned CYC = psc_pkg::GLITCH_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // sampled comparator level
    input wire logic sample_in,
    // filtered level and edge pulses
    output logic filt_out,
    output logic rise_pulse,
    output logic fall_pulse
);

    localparam int unsigned CNT_W = $clog2(CYC + 1);

    typedef struct packed {
        logic filt;
        logic [CNT_W-1:0] cnt;
        logic rise;
        logic fall;
    } psc_filt_state_t;

    psc_filt_state_t s_q;
    psc_filt_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        if (sample_in != s_q.filt) begin
            // new level must hold for CYC samples in a row
            if (s_q.cnt == CNT_W'(CYC - 1)) begin
                s_d.filt = sample_in;
                s_d.cnt = '0;
                s_d.rise = sample_in;
                s_d.fall = ~sample_in;
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end else begin
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign filt_out = s_q.filt;
    assign rise_pulse = s_q.rise;
    assign fall_pulse = s_q.fall;

endmodule : psc_glitch_filter

/* dv/psc_top_props.sv */
// assertion checker bound to the supply comparator control top
`timescale 1ns/100ps
module psc_top_props #(
    parameter int unsigned LEVEL_W = 10,
    parameter int unsigned FILT_CYC = 2
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // comparator and dac
    input wire logic cmp_raw,
    input wire logic cmp_power_on,
    input wire logic dac_power_on,
    input wire logic dac_to_inverting,
    input wire logic [psc_pkg::SEL_W-1:0] pos_input_sel,
    input wire logic [psc_pkg::SRC_PINS-1:0] pad_input_off,
    // power modes
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic group_idle_stop,
    input wire logic idle_stop_out,
    input wire logic wake_req,
    // events
    input wire logic adc_trigger,
    input wire logic int_pulse,
    input wire logic irq
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // a trigger lasts exactly one cycle
    sequence one_shot;
        adc_trigger ##1 !adc_trigger;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    dac_tie_a: assert property (dac_to_inverting)
        else $error("inverting input not on dac");
    power_down_a: assert property (!dac_power_on |-> !cmp_power_on)
        else $error("comparator powered while disabled");
    idle_stop_a: assert property (
        idle_mode && (idle_stop_out || group_idle_stop) |-> !cmp_power_on)
        else $error("comparator runs in idle despite stop");
    pad_off_a: assert property (
        pad_input_off == (dac_power_on ? 4'h1 << pos_input_sel : 4'h0))
        else $error("pad buffer control wrong");
    glitch_block_a: assert property (
        adc_trigger |-> $past(cmp_raw, 2) == $past(cmp_raw, 3))
        else $error("trigger from unsteady input");
    pulse_one_a: assert property ($rose(adc_trigger) |-> one_shot)
        else $error("trigger pulse too wide");
    irq_follow_a: assert property (int_pulse |-> irq)
        else $error("interrupt pulse without irq");
    wake_mode_a: assert property (
        wake_req |-> sleep_mode || idle_mode)
        else $error("wake outside low power");
    wake_path_a: assert property (
        sleep_mode && cmp_power_on && $past(sleep_mode)
        && $past(cmp_power_on) && $changed(cmp_raw) |-> $changed(wake_req))
        else $error("wake path not direct");
endmodule : psc_top_props

bind psc_top psc_top_props #(.LEVEL_W(LEVEL_W), .FILT_CYC(FILT_CYC)) u_props (
    .hclk(hclk), .hresetn(hresetn), .cmp_raw(cmp_raw),
    .cmp_power_on(cmp_power_on), .dac_power_on(dac_power_on),
    .dac_to_inverting(dac_to_inverting), .pos_input_sel(pos_input_sel),
    .pad_input_off(pad_input_off), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .group_idle_stop(group_idle_stop),
    .idle_stop_out(idle_stop_out), .wake_req(wake_req),
    .adc_trigger(adc_trigger), .int_pulse(int_pulse), .irq(irq)
);

/* dv/psc_sense_model.sv */
// behavioural analog front end producing the raw comparator output
`timescale 1ns/100ps
module psc_sense_model (
    // clock
    input wire logic hclk,
    // analog pin levels and injected glitch
    input wire logic [39:0] pin_lvl,
    input wire logic blip,
    // design side
    input wire logic cmp_power_on,
    input wire logic [9:0] dac_code,
    input wire logic [1:0] pos_input_sel,
    output logic cmp_raw
);
    logic junk_q = 1'b0;
    logic [9:0] pos;
    // unpowered comparator output wanders every cycle
    always @(posedge hclk) junk_q <= ~junk_q;
    assign pos = pin_lvl[pos_input_sel * 10 +: 10];
    assign cmp_raw = cmp_power_on ? (pos > dac_code) ^ blip : junk_q;
endmodule : psc_sense_model

/* dv/power_supply_comparator_control_bench.sv */
// self-checking bench for the supply comparator control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
end
module power_supply_comparator_control_bench;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hreadyout, blip, seen;
    logic [4:0] haddr;
    logic [1:0] htrans, s, dac_range, pos_input_sel;
    logic [31:0] hwdata, hrdata, rv, lv;
    logic [39:0] pin_lvl;
    logic [9:0] lvl, dac_code;
    logic [3:0] pad_input_off;
    logic cmp_raw, cmp_power_on, dac_power_on, dac_to_inverting, wake_req;
    logic sleep_mode, idle_mode, group_idle_stop, idle_stop_out, irq;
    logic adc_trigger, pwm_current_limit, pwm_period_trunc, pwm_fault;
    logic int_pulse;
    int seed, err_total, tests_run, i, k, n;

    always #25 hclk = ~hclk;

    psc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp(), .cmp_raw, .cmp_power_on, .dac_power_on, .dac_code,
        .dac_range, .dac_to_inverting, .pos_input_sel, .pad_input_off,
        .sleep_mode, .idle_mode, .group_idle_stop, .idle_stop_out,
        .wake_req, .adc_trigger, .pwm_current_limit, .pwm_period_trunc,
        .pwm_fault, .int_pulse, .irq);
    psc_sense_model i_sense (.hclk, .pin_lvl, .blip, .cmp_power_on,
        .dac_code, .pos_input_sel, .cmp_raw);

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic bus(input logic w, input logic [4:0] a,
            input logic [31:0] d);
        int c;
        c = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do begin
            @(posedge hclk);
            c++;
        end while (hreadyout !== 1'b1 && c < 20);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            c++;
        end while (hreadyout !== 1'b1 && c < 40);
        rv = hrdata;
        if (c >= 20) begin
            err_total++;
            test_done();
        end
        @(posedge hclk);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [4:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rd

    function automatic logic [31:0] ctrl(input logic en, input logic stp,
            input logic [1:0] sl, input logic inv);
        return {16'h0, en, 1'b0, stp, 5'h0, sl, 4'h0, inv, 1'b0};
    endfunction : ctrl

    function automatic logic [1:0] exp_rng(input logic ext, input logic r);
        return ext ? 2'h2 : {1'b0, ~r};
    endfunction : exp_rng

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 76;
        err_total = 0;
        tests_run = 0;
        {hresetn, hsel, hwrite, blip, sleep_mode} = 5'h0;
        {idle_mode, group_idle_stop, haddr, htrans} = 9'h0;
        hwdata = 32'h0;
        pin_lvl = 40'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, unmapped write ignored
        wr(5'h14, 32'hffff_ffff);
        for (i = 0; i < 6; i++) begin
            rd(5'(i * 4));
            `CHK("reset read", 32'h0, rv)
        end
        `CHK("dac off", 1'b0, dac_power_on)
        for (i = 0; i < 4; i++) begin
            lv = $random(seed);
            wr(psc_pkg::OFF_LEVEL, lv);
            rd(psc_pkg::OFF_LEVEL);
            `CHK("level", {22'h0, lv[9:0]}, rv)
            `CHK("dac code", lv[9:0], dac_code)
        end
        for (i = 0; i < 4; i++) begin
            wr(psc_pkg::OFF_CTRL, {26'h0, i[1], 4'h0, i[0]});
            `CHK("range", exp_rng(i[1], i[0]), dac_range)
        end
        for (i = 0; i < 8; i++) begin
            wr(psc_pkg::OFF_CTRL, ctrl(i[2], 1'b0, i[1:0], 1'b0));
            `CHK("pad", i[2] ? 4'h1 << i[1:0] : 4'h0, pad_input_off)
            `CHK("mux", i[1:0], pos_input_sel)
            `CHK("power", {2{i[2]}}, {cmp_power_on, dac_power_on})
        end
        `CHK("dac tie", 1'b1, dac_to_inverting)
        // events: random level and pin, then the top corner
        for (k = 0; k < 2; k++) begin
            lvl = k ? 10'h3fe : 10'($random(seed)) & 10'h3fe;
            s = 2'($random(seed));
            pin_lvl <= 40'h0;
            wr(psc_pkg::OFF_LEVEL, {22'h0, lvl});
            wr(psc_pkg::OFF_USE, 32'hf);
            wr(psc_pkg::OFF_MASK, 32'h1);
            wr(psc_pkg::OFF_CTRL, ctrl(1'b1, 1'b0, s, 1'b0));
            wr(psc_pkg::OFF_STAT, 32'h3);
            `CHK("quiet irq", 1'b0, irq)
            pin_lvl <= 40'(lvl + 10'h1) << (10 * s);
            n = 0;
            while (adc_trigger !== 1'b1 && n < 8) begin
                @(posedge hclk);
                n++;
            end
            `CHK("adc", 1'b1, adc_trigger)
            if (adc_trigger !== 1'b1) test_done();
            `CHK("uses", 3'h7, {int_pulse, pwm_period_trunc, pwm_fault})
            @(posedge hclk);
            `CHK("pulse end", 1'b0, adc_trigger)
            `CHK("limit", 2'h3, {pwm_current_limit, irq})
            rd(psc_pkg::OFF_STAT);
            `CHK("rise flag", 32'h1, rv)
            rd(psc_pkg::OFF_CTRL);
            `CHK("state", 1'b1, rv[3])
            wr(psc_pkg::OFF_MASK, 32'h0);
            `CHK("masked irq", 1'b0, irq)
            wr(psc_pkg::OFF_STAT, 32'h1);
            wr(psc_pkg::OFF_MASK, 32'h1);
            `CHK("cleared irq", 1'b0, irq)
            wr(psc_pkg::OFF_CTRL, ctrl(1'b1, 1'b0, s, 1'b1));
            repeat (3) @(posedge hclk);
            rd(psc_pkg::OFF_CTRL);
            `CHK("inverted", 1'b0, rv[3])
            wr(psc_pkg::OFF_CTRL, ctrl(1'b1, 1'b0, s, 1'b0));
            pin_lvl <= 40'h0;
            repeat (4) @(posedge hclk);
            wr(psc_pkg::OFF_STAT, 32'h3);
            blip <= 1'b1;
            @(posedge hclk);
            blip <= 1'b0;
            seen = 1'b0;
            repeat (6) begin
                @(posedge hclk);
                seen |= adc_trigger | int_pulse;
            end
            `CHK("blip", 1'b0, seen)
        end
        for (i = 0; i < 4; i++) begin
            wr(psc_pkg::OFF_CTRL, ctrl(1'b1, i[0], 2'h0, 1'b0));
            idle_mode <= 1'b1;
            group_idle_stop <= i[1];
            @(posedge hclk);
            `CHK("idle power", ~(i[0] | i[1]), cmp_power_on)
            `CHK("stop bit", i[0], idle_stop_out)
            idle_mode <= 1'b0;
            @(posedge hclk);
            `CHK("run power", 1'b1, cmp_power_on)
        end
        sleep_mode <= 1'b1;
        @(posedge hclk);
        `CHK("no wake", 1'b0, wake_req)
        pin_lvl <= 40'h3ff;
        @(posedge hclk);
        `CHK("wake", 2'h2, {wake_req, adc_trigger})
        sleep_mode <= 1'b0;
        idle_mode <= 1'b1;
        @(posedge hclk);
        `CHK("stopped wake", 1'b0, wake_req)
        group_idle_stop <= 1'b0;
        wr(psc_pkg::OFF_CTRL, ctrl(1'b1, 1'b0, 2'h0, 1'b0));
        `CHK("idle wake", 1'b1, wake_req)
        idle_mode <= 1'b0;
        test_done();
    end
endmodule : power_supply_comparator_control_bench
